// ---- pkg/scm_pkg.sv ----
package scm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] SCM_OFF_SCC  = 5'h00;
  localparam logic [4:0] SCM_OFF_IRC  = 5'h04;
  localparam logic [4:0] SCM_OFF_FXT  = 5'h08;
  localparam logic [4:0] SCM_OFF_SXT  = 5'h0c;
  localparam logic [4:0] SCM_OFF_STAT = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCM_EN_BIT   = 0;
  localparam int SCM_STB_BIT  = 1;
  localparam int SCM_MODE_BIT = 2;
  localparam int SCM_FRQ_LSB  = 2;
  localparam int SCM_FRQ_MSB  = 3;
  localparam int SCM_BUSY_BIT = 0;
  localparam int SCM_ACT_LSB  = 1;
  localparam int SCM_ACT_MSB  = 3;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SCM_SCC_RST     = 8'h00;
  localparam logic       SCM_IRC_EN_RST  = 1'b1;
  localparam logic [1:0] SCM_FRQ_RST     = 2'h0;
  localparam logic [1:0] SCM_FRQ_8M      = 2'h0;
  localparam logic [1:0] SCM_FRQ_12M     = 2'h1;
  localparam logic [1:0] SCM_FRQ_16M     = 2'h2;
  localparam logic [1:0] SCM_FRQ_8M_ALT  = 2'h3;
  localparam logic [2:0] SCM_SEL_SLOW    = 3'h7;
  localparam logic [2:0] SCM_SW_TICKS    = 3'h4;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SCM_CLK_NS        = 50;
  localparam int SCM_IRC_START_NS  = 16000;
  localparam int SCM_FXT_START_NS  = 1000000;
  localparam int SCM_SXT_START_NS  = 1000000;
  localparam logic [15:0] SCM_IRC_START_CYC =
    16'((SCM_IRC_START_NS + SCM_CLK_NS - 1) / SCM_CLK_NS);
  localparam logic [15:0] SCM_FXT_START_CYC =
    16'((SCM_FXT_START_NS + SCM_CLK_NS - 1) / SCM_CLK_NS);
  localparam logic [15:0] SCM_SXT_START_CYC =
    16'((SCM_SXT_START_NS + SCM_CLK_NS - 1) / SCM_CLK_NS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] sysclk_select;
    logic       rsv;
    logic       fast_source_select;
    logic       slow_source_select;
    logic       fast_keep_on_halt;
    logic       slow_keep_on_halt;
  } scm_scc_t;

  typedef struct packed {
    logic internal_fast_rc;
    logic external_fast_crystal;
    logic external_slow_crystal;
    logic internal_slow_rc;
  } scm_osc_en_t;

  typedef enum logic [2:0] {
    SCM_RUN,
    SCM_SLEEP,
    SCM_IDLE_SLOW_ONLY,
    SCM_IDLE_BOTH_CLOCKS,
    SCM_IDLE_FAST_ONLY
  } scm_mode_t;

endpackage : scm_pkg

// ---- logic/scm_top.sv ----
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// R1 - Select code 000..110 picks fast clock divided 1..64; 111 picks slow.
// R2 - Fast source bit: 0 internal fast RC, 1 fast crystal.
// R3 - Slow source bit: 0 internal slow RC, 1 slow crystal.
// R4 - Fast mode runs CPU from selected fast clock divided 1 to 64.
// R5 - Halt with both keep bits 0 enters sleep, fast RC and both crystals off.
// R6 - In sleep internal slow RC runs only while watchdog is enabled.
// R7 - Halt with fast keep 0, slow keep 1 enters idle, slow clock only.
// R8 - Halt with both keep bits 1 enters idle with both clocks running.
// R9 - Halt with fast keep 1, slow keep 0 enters idle, fast clock only.
// R10 - Keep bits decide if fast RC and both crystals run while halted; 1 enables.
// R11 - In slow mode fast oscillator follows its enable bit.
// R12 - Clock switch takes 4 current ticks then one target tick.
// R13 - RC frequency field: 00 8MHz, 01 12MHz, 10 16MHz, 11 8MHz.
// R14 - Software matches RC frequency field to the configured frequency.
// R15 - New RC frequency is applied only once its stable flag is 1.
// R16 - RC enable or frequency change clears stable flag until settled.
// R17 - RC enable bit turns oscillator on or off; resets to 1.
// R18 - Crystal drive bit: 0 low current up to 10MHz, 1 high current.
// R19 - Drive bit writes ignored while both pins assigned and crystal on.
// R20 - Fast crystal enable clears stable flag, sets it once settled.
// R21 - Slow crystal enable clears stable flag, sets it once settled.
// R22 - Unused bits read 0; slow crystal register bit 2 reads 1.
// R23 - Software checks stable flag before using a restarted fast clock.
// R24 - Fast RC and both crystals settle after a configurable start-up count; the fast RC count is the fixed SCM_IRC_START_CYC.
// R25 - Clock mux changes only on a target tick, glitch free.

// ------------------------------------------------------------------
// Start-up counter for one oscillator
// ------------------------------------------------------------------
module scm_osc_start #(
  parameter logic [15:0] START_CYC = 16'h0001
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic en,
  input  wire logic restart,
  output logic      stable_ff
);
  logic [15:0] cnt_ff;

  always_ff @(posedge clk_sys) begin
    if (rst || !en || restart) begin
      cnt_ff    <= START_CYC;                          // [R24]
      stable_ff <= 1'b0;                               // [R16] [R20] [R21]
    end else if (cnt_ff > 16'h0001) begin
      cnt_ff <= cnt_ff - 16'h0001;
    end else begin
      stable_ff <= 1'b1;                               // [R24]
    end
  end
endmodule : scm_osc_start

// ------------------------------------------------------------------
// System clock and mode control
// ------------------------------------------------------------------
module scm_top #(
  parameter logic [15:0] FXT_START_CYC = scm_pkg::SCM_FXT_START_CYC,
  parameter logic [15:0] SXT_START_CYC = scm_pkg::SCM_SXT_START_CYC
) (
  input  wire logic          clk_sys,
  input  wire logic          rst,
  input  wire logic [4:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          irc_fast_tick,
  input  wire logic          xtal_fast_tick,
  input  wire logic          irc_slow_tick,
  input  wire logic          xtal_slow_tick,
  input  wire logic          fast_xtal_pins_on,
  input  wire logic          watchdog_enable,
  input  wire logic          halt_req,
  input  wire logic          wake_req,
  output scm_pkg::scm_osc_en_t osc_en,
  output logic [1:0]         int_fast_rc_freq,
  output logic               fast_crystal_drive_mode,
  output logic               cpu_clk_en,
  output logic               sys_clk_en,
  output logic               fast_clk_en,
  output logic               slow_clk_en,
  output scm_pkg::scm_mode_t mode
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scm_pkg::scm_scc_t    scc_ff;
  scm_pkg::scm_mode_t   mode_ff;
  scm_pkg::scm_osc_en_t osc_en_ff, nxt_osc_en;
  logic [1:0]           irc_freq_ff, frq_applied_ff;
  logic                 irc_en_ff, fxt_drive_ff, fxt_en_ff, sxt_en_ff;
  logic                 irc_stable, fxt_stable, sxt_stable, fxt_locked;
  logic                 wait_ff, wr, irc_restart;
  logic [31:0]          rdata_ff;
  logic [7:0]           nxt_rdata;
  logic [5:0]           div_ff;
  logic [2:0]           act_sel_ff, sw_cnt_ff;
  logic                 fast_tick, slow_tick, cur_tick, tgt_tick;
  logic                 halted, fast_ok, slow_ok, fast_need, slow_need;
  logic                 sys_tick_ff, cpu_tick_ff, fast_en_ff, slow_en_ff;

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  assign wr = avs_write && !wait_ff && avs_byteenable[0];
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
    end
  end

  always_comb begin
    nxt_rdata = 8'h00;                                 // [R22]
    unique case (avs_address)
      scm_pkg::SCM_OFF_SCC: begin
        nxt_rdata = scc_ff;
      end
      scm_pkg::SCM_OFF_IRC: begin
        nxt_rdata[scm_pkg::SCM_FRQ_MSB:scm_pkg::SCM_FRQ_LSB] = irc_freq_ff;
        nxt_rdata[scm_pkg::SCM_STB_BIT] = irc_stable;
        nxt_rdata[scm_pkg::SCM_EN_BIT]  = irc_en_ff;
      end
      scm_pkg::SCM_OFF_FXT: begin
        nxt_rdata[scm_pkg::SCM_MODE_BIT] = fxt_drive_ff;
        nxt_rdata[scm_pkg::SCM_STB_BIT]  = fxt_stable;
        nxt_rdata[scm_pkg::SCM_EN_BIT]   = fxt_en_ff;
      end
      scm_pkg::SCM_OFF_SXT: begin
        nxt_rdata[scm_pkg::SCM_MODE_BIT] = 1'b1;       // [R22]
        nxt_rdata[scm_pkg::SCM_STB_BIT]  = sxt_stable;
        nxt_rdata[scm_pkg::SCM_EN_BIT]   = sxt_en_ff;
      end
      scm_pkg::SCM_OFF_STAT: begin
        nxt_rdata[scm_pkg::SCM_BUSY_BIT] = (scc_ff.sysclk_select != act_sel_ff);
        nxt_rdata[scm_pkg::SCM_ACT_MSB:scm_pkg::SCM_ACT_LSB] = act_sel_ff;
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read && wait_ff) begin
      rdata_ff <= {24'h00_0000, nxt_rdata};
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  assign fxt_locked  = fast_xtal_pins_on && fxt_en_ff;
  assign irc_restart = wr && (avs_address == scm_pkg::SCM_OFF_IRC) &&
    (avs_writedata[scm_pkg::SCM_FRQ_MSB:scm_pkg::SCM_FRQ_LSB] != irc_freq_ff);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scc_ff <= scm_pkg::SCM_SCC_RST;
    end else if (wr && avs_address == scm_pkg::SCM_OFF_SCC) begin
      scc_ff     <= avs_writedata[7:0];
      scc_ff.rsv <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irc_freq_ff <= scm_pkg::SCM_FRQ_RST;
      irc_en_ff   <= scm_pkg::SCM_IRC_EN_RST;          // [R17]
    end else if (wr && avs_address == scm_pkg::SCM_OFF_IRC) begin
      irc_freq_ff <= avs_writedata[scm_pkg::SCM_FRQ_MSB:scm_pkg::SCM_FRQ_LSB];
      irc_en_ff   <= avs_writedata[scm_pkg::SCM_EN_BIT]; // [R17]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fxt_drive_ff <= 1'b0;
      fxt_en_ff    <= 1'b0;
    end else if (wr && avs_address == scm_pkg::SCM_OFF_FXT) begin
      if (!fxt_locked) begin
        fxt_drive_ff <= avs_writedata[scm_pkg::SCM_MODE_BIT]; // [R18] [R19]
      end
      fxt_en_ff <= avs_writedata[scm_pkg::SCM_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sxt_en_ff <= 1'b0;
    end else if (wr && avs_address == scm_pkg::SCM_OFF_SXT) begin
      sxt_en_ff <= avs_writedata[scm_pkg::SCM_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Applied RC frequency
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frq_applied_ff <= scm_pkg::SCM_FRQ_8M;
    end else if (irc_stable && !irc_restart) begin    // [R15]
      frq_applied_ff <= (irc_freq_ff == scm_pkg::SCM_FRQ_8M_ALT) ?
                        scm_pkg::SCM_FRQ_8M : irc_freq_ff; // [R13]
    end
  end

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ff <= scm_pkg::SCM_RUN;
    end else if (mode_ff == scm_pkg::SCM_RUN && halt_req) begin
      unique case ({scc_ff.fast_keep_on_halt, scc_ff.slow_keep_on_halt})
        2'b00: mode_ff <= scm_pkg::SCM_SLEEP;             // [R5]
        2'b01: mode_ff <= scm_pkg::SCM_IDLE_SLOW_ONLY;    // [R7]
        2'b11: mode_ff <= scm_pkg::SCM_IDLE_BOTH_CLOCKS;  // [R8]
        2'b10: mode_ff <= scm_pkg::SCM_IDLE_FAST_ONLY;    // [R9]
      endcase
    end else if (mode_ff != scm_pkg::SCM_RUN && wake_req) begin
      mode_ff <= scm_pkg::SCM_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  assign halted    = (mode_ff != scm_pkg::SCM_RUN);
  assign fast_ok   = !halted || scc_ff.fast_keep_on_halt;   // [R10]
  assign slow_ok   = !halted || scc_ff.slow_keep_on_halt;   // [R10]
  assign fast_need = !halted &&
    ((scc_ff.sysclk_select != scm_pkg::SCM_SEL_SLOW) ||
     (act_sel_ff != scm_pkg::SCM_SEL_SLOW));
  assign slow_need = !halted &&
    ((scc_ff.sysclk_select == scm_pkg::SCM_SEL_SLOW) ||
     (act_sel_ff == scm_pkg::SCM_SEL_SLOW));

  always_comb begin
    nxt_osc_en.internal_fast_rc = fast_ok &&                // [R11] [R17]
      (irc_en_ff || (fast_need && !scc_ff.fast_source_select));
    nxt_osc_en.external_fast_crystal = fast_ok &&           // [R11]
      (fxt_en_ff || (fast_need && scc_ff.fast_source_select));
    nxt_osc_en.external_slow_crystal = slow_ok &&
      (sxt_en_ff || (slow_need && scc_ff.slow_source_select));
    nxt_osc_en.internal_slow_rc =
      (mode_ff != scm_pkg::SCM_SLEEP) || watchdog_enable;   // [R6]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      osc_en_ff <= 4'h0;
    end else begin
      osc_en_ff <= nxt_osc_en;
    end
  end
  scm_osc_start #(.START_CYC(scm_pkg::SCM_IRC_START_CYC)) u_irc_start (
    .clk_sys(clk_sys), .rst(rst), .en(osc_en_ff.internal_fast_rc),
    .restart(irc_restart), .stable_ff(irc_stable));        // [R16]
  scm_osc_start #(.START_CYC(FXT_START_CYC)) u_fxt_start (
    .clk_sys(clk_sys), .rst(rst), .en(osc_en_ff.external_fast_crystal),
    .restart(1'b0), .stable_ff(fxt_stable));
  scm_osc_start #(.START_CYC(SXT_START_CYC)) u_sxt_start (
    .clk_sys(clk_sys), .rst(rst), .en(osc_en_ff.external_slow_crystal),
    .restart(1'b0), .stable_ff(sxt_stable));

  // ----------------------------------------------------------------
  // Clock ticks, divider and glitch-free switch
  // ----------------------------------------------------------------
  assign fast_tick = scc_ff.fast_source_select ?            // [R2]
    (xtal_fast_tick && fxt_stable) : (irc_fast_tick && irc_stable);
  assign slow_tick = scc_ff.slow_source_select ?            // [R3]
    (xtal_slow_tick && sxt_stable) :
    (irc_slow_tick && osc_en_ff.internal_slow_rc);

  function automatic logic sel_tick(input logic [2:0] sel, input logic ft,
                                    input logic st, input logic [5:0] dv);
    logic [5:0] mask;
    mask = 6'((7'h01 << sel) - 7'h01);
    if (sel == scm_pkg::SCM_SEL_SLOW) begin
      sel_tick = st;                                        // [R1]
    end else begin
      sel_tick = ft && ((dv & mask) == mask);               // [R1] [R4]
    end
  endfunction : sel_tick
  assign cur_tick = sel_tick(act_sel_ff, fast_tick, slow_tick, div_ff);
  assign tgt_tick = sel_tick(scc_ff.sysclk_select, fast_tick, slow_tick,
                             div_ff);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_ff <= 6'h00;
    end else if (fast_tick) begin
      div_ff <= div_ff + 6'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_sel_ff <= 3'h0;
      sw_cnt_ff  <= 3'h0;
    end else if (scc_ff.sysclk_select == act_sel_ff) begin
      sw_cnt_ff <= 3'h0;
    end else if (sw_cnt_ff < scm_pkg::SCM_SW_TICKS) begin
      sw_cnt_ff <= sw_cnt_ff + {2'h0, cur_tick};            // [R12]
    end else if (tgt_tick) begin
      act_sel_ff <= scc_ff.sysclk_select;                   // [R25]
      sw_cnt_ff  <= 3'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_tick_ff <= 1'b0;
      cpu_tick_ff <= 1'b0;
      fast_en_ff  <= 1'b0;
      slow_en_ff  <= 1'b0;
    end else begin
      sys_tick_ff <= cur_tick;
      cpu_tick_ff <= cur_tick && !halted;                   // [R5]
      fast_en_ff  <= fast_tick && fast_ok;                  // [R9]
      slow_en_ff  <= slow_tick && slow_ok;                  // [R7]
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_readdata            = rdata_ff;
  assign avs_waitrequest         = wait_ff;
  assign osc_en                  = osc_en_ff;
  assign int_fast_rc_freq        = frq_applied_ff;
  assign fast_crystal_drive_mode = fxt_drive_ff;
  assign cpu_clk_en              = cpu_tick_ff;
  assign sys_clk_en              = sys_tick_ff;
  assign fast_clk_en             = fast_en_ff;
  assign slow_clk_en             = slow_en_ff;
  assign mode                    = mode_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sleep_osc_off_a: assert property ( // [R5]
    mode_ff == scm_pkg::SCM_SLEEP ##1 mode_ff == scm_pkg::SCM_SLEEP |->
      !osc_en_ff.internal_fast_rc && !osc_en_ff.external_fast_crystal &&
      !osc_en_ff.external_slow_crystal && !cpu_tick_ff)
    else $error("oscillator left running in sleep");
  sleep_wdt_rc_a: assert property ( // [R6]
    mode_ff == scm_pkg::SCM_SLEEP |=>
      osc_en_ff.internal_slow_rc == $past(watchdog_enable))
    else $error("slow RC does not follow watchdog in sleep");
  idle_slow_a: assert property ( // [R7]
    mode_ff == scm_pkg::SCM_RUN && halt_req && !scc_ff.fast_keep_on_halt &&
    scc_ff.slow_keep_on_halt |=> mode_ff == scm_pkg::SCM_IDLE_SLOW_ONLY)
    else $error("wrong idle mode for slow keep");
  idle_both_a: assert property ( // [R8]
    mode_ff == scm_pkg::SCM_RUN && halt_req && scc_ff.fast_keep_on_halt &&
    scc_ff.slow_keep_on_halt |=> mode_ff == scm_pkg::SCM_IDLE_BOTH_CLOCKS)
    else $error("wrong idle mode for both keeps");
  idle_fast_a: assert property ( // [R9]
    mode_ff == scm_pkg::SCM_IDLE_FAST_ONLY && slow_tick |=> !slow_en_ff)
    else $error("slow clock leaks in fast-only idle");
  switch_delay_a: assert property ( // [R12]
    act_sel_ff != $past(act_sel_ff) |->
      $past(sw_cnt_ff) == scm_pkg::SCM_SW_TICKS)
    else $error("clock switched before four current ticks");
  slow_sel_tick_a: assert property ( // [R1]
    act_sel_ff == scm_pkg::SCM_SEL_SLOW && slow_tick |=> sys_tick_ff)
    else $error("slow selection does not pass slow tick");
  freq_wait_a: assert property ( // [R15]
    frq_applied_ff != $past(frq_applied_ff) |-> $past(irc_stable))
    else $error("RC frequency applied before stable");
  freq_clear_a: assert property ( // [R16]
    irc_restart |=> !irc_stable [*2])
    else $error("RC stable flag not cleared on change");
  drive_lock_a: assert property ( // [R19]
    fxt_locked && wr |=> $stable(fxt_drive_ff))
    else $error("drive mode changed while locked");
  bus_answer_a: assert property (
    (avs_read || avs_write) && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("bus answer not after one wait cycle");

  sleep_c:  cover property (mode_ff == scm_pkg::SCM_SLEEP ##1 wake_req);
  switch_c: cover property (act_sel_ff != scm_pkg::SCM_SEL_SLOW ##1
                            act_sel_ff == scm_pkg::SCM_SEL_SLOW);
  stable_c: cover property (irc_restart ##[1:400] irc_stable);

endmodule : scm_top

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  logic                 clk_sys, rst, avs_read, avs_write, halt_req, wake_req;
  logic [4:0]           avs_address;
  logic [31:0]          avs_writedata, avs_readdata, d;
  logic [3:0]           avs_byteenable;
  logic                 avs_waitrequest, irc_fast_tick, xtal_fast_tick;
  logic                 irc_slow_tick, xtal_slow_tick, fast_xtal_pins_on;
  logic                 watchdog_enable, fast_crystal_drive_mode, cpu_clk_en;
  logic                 sys_clk_en, fast_clk_en, slow_clk_en;
  logic [1:0]           int_fast_rc_freq;
  scm_pkg::scm_osc_en_t osc_en;
  scm_pkg::scm_mode_t   mode;
  int                   bad_count, num_checks, cs, cf, cl, cc;
  int                   tc = 0;
  logic [4:0] ra[5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
  logic [7:0] rv[5] = '{8'h00, 8'h01, 8'h00, 8'h04, 8'h00};
  logic [1:0] fc[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
  logic [1:0] fa[4] = '{2'h1, 2'h2, 2'h0, 2'h0};
  logic [1:0] fo[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  scm_pkg::scm_mode_t hm[5] = '{scm_pkg::SCM_SLEEP,
    scm_pkg::SCM_IDLE_SLOW_ONLY, scm_pkg::SCM_IDLE_FAST_ONLY,
    scm_pkg::SCM_IDLE_BOTH_CLOCKS, scm_pkg::SCM_SLEEP};

  scm_top #(.FXT_START_CYC(16'h0010), .SXT_START_CYC(16'h0010)) scm_top_i (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irc_fast_tick(irc_fast_tick),
    .xtal_fast_tick(xtal_fast_tick), .irc_slow_tick(irc_slow_tick),
    .xtal_slow_tick(xtal_slow_tick), .fast_xtal_pins_on(fast_xtal_pins_on),
    .watchdog_enable(watchdog_enable), .halt_req(halt_req),
    .wake_req(wake_req), .osc_en(osc_en),
    .int_fast_rc_freq(int_fast_rc_freq),
    .fast_crystal_drive_mode(fast_crystal_drive_mode),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en),
    .fast_clk_en(fast_clk_en), .slow_clk_en(slow_clk_en), .mode(mode));

  // ----------------------------------------------------------------
  // Clock and oscillator tick sources
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    tc <= tc + 1;
    irc_fast_tick <= (tc % 2 == 0);
    xtal_fast_tick <= (tc % 3 == 0);
    irc_slow_tick <= (tc % 8 == 0);
    xtal_slow_tick <= (tc % 12 == 0);
  end

  // ----------------------------------------------------------------
  // Bus access and helpers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
    int n;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 30);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      final_report();
    end
  endtask : bus

  // Polls a register bit until it reaches a value
  task automatic wbit(input logic [4:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      bus(1'b0, a, 8'h00);
      n++;
    end while (d[b] !== v && n < 3000);
    if (d[b] !== v) begin
      bad_count++;
      final_report();
    end
  endtask : wbit

  // Counts clock enable pulses over a window
  task automatic cnt(input int n);
    cs = 0;
    cf = 0;
    cl = 0;
    cc = 0;
    repeat (n) begin
      @(posedge clk_sys);
      cs += int'(sys_clk_en);
      cf += int'(fast_clk_en);
      cl += int'(slow_clk_en);
      cc += int'(cpu_clk_en);
    end
  endtask : cnt

  task final_report;
    if (bad_count == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    fast_xtal_pins_on = 1'b0;
    watchdog_enable = 1'b0;
    halt_req = 1'b0;
    wake_req = 1'b0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("irc_on", 1'b1, osc_en.internal_fast_rc)
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 8'h00);
      `CHK("reset_val", {24'h0, rv[i]}, d)
    end
    bus(1'b1, 5'h14, 8'hff);
    bus(1'b0, 5'h14, 8'h00);
    `CHK("unmapped", 32'h0, d)
    wbit(5'h04, 1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 5'h04, {4'h0, fc[i], 2'b01});
      bus(1'b0, 5'h04, 8'h00);
      `CHK("irc_stable", 1'b0, d[1])
      `CHK("freq_hold", fo[i], int_fast_rc_freq)
      wbit(5'h04, 1, 1'b1);
      `CHK("freq", fa[i], int_fast_rc_freq)
    end
    bus(1'b1, 5'h08, 8'h01);
    bus(1'b0, 5'h08, 8'h00);
    `CHK("fxt_stable", 1'b0, d[1])
    wbit(5'h08, 1, 1'b1);
    fast_xtal_pins_on <= 1'b1;
    bus(1'b1, 5'h08, 8'h05);
    repeat (2) @(posedge clk_sys);
    `CHK("drive_locked", 1'b0, fast_crystal_drive_mode)
    fast_xtal_pins_on <= 1'b0;
    bus(1'b1, 5'h08, 8'h05);
    repeat (2) @(posedge clk_sys);
    `CHK("drive", 1'b1, fast_crystal_drive_mode)
    bus(1'b1, 5'h0c, 8'h01);
    bus(1'b0, 5'h0c, 8'h00);
    `CHK("sxt_stable", 1'b0, d[1])
    wbit(5'h0c, 1, 1'b1);
    `CHK("sxt_reg", 32'h7, d)
    for (int h = 0; h < 2; h++) begin
      for (int k = 0; k < 8; k++) begin
        bus(1'b1, 5'h00, {k[2:0], 1'b0, h[0], 3'b000});
        wbit(5'h10, 0, 1'b0);
        `CHK("active", k[2:0], d[3:1])
        cnt(768);
        `CHK("sys_ticks", k == 7 ? 96 : (h ? 256 : 384) >> k, cs)
      end
    end
    bus(1'b1, 5'h00, 8'he4);
    wbit(5'h10, 0, 1'b0);
    cnt(768);
    `CHK("slow_xtal_ticks", 64, cs)
    bus(1'b1, 5'h00, 8'h00);
    wbit(5'h10, 0, 1'b0);
    for (int i = 0; i < 5; i++) begin
      watchdog_enable <= (i == 4);
      bus(1'b1, 5'h00, {6'h00, i[1:0]});
      wbit(5'h04, 1, 1'b1);
      @(posedge clk_sys);
      halt_req <= 1'b1;
      @(posedge clk_sys);
      halt_req <= 1'b0;
      @(posedge clk_sys);
      `CHK("mode", hm[i], mode)
      repeat (3) @(posedge clk_sys);
      cnt(96);
      `CHK("cpu_ticks", 0, cc)
      `CHK("fast_on", i[1], cf > 0)
      `CHK("slow_on", i[0], cl > 0)
      `CHK("osc_keep", {i[1], i[1], i[0]}, osc_en[3:1])
      if (i[1:0] == 2'h0) `CHK("internal_slow_rc", i == 4, osc_en.internal_slow_rc)
      wake_req <= 1'b1;
      @(posedge clk_sys);
      wake_req <= 1'b0;
      @(posedge clk_sys);
      `CHK("wake", scm_pkg::SCM_RUN, mode)
    end
    final_report();
  end
endmodule : tb_top
